// >>> design/twc_timer_ctrl.sv
`timescale 1ns/10ps
module twc_timer_ctrl #(
  parameter int NCH = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire twc_pkg::twc_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire twc_pkg::twc_word_t pwdata,
  input wire logic [3:0] pstrb,
  output twc_pkg::twc_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] port_level,
  output logic [NCH-1:0] wave_pin_q,
  output logic [NCH-1:0] wave_oe_q,
  output logic overflow_q
);
  import twc_pkg::*;

  logic pready_q;
  logic pslverr_q;
  twc_word_t prdata_q;
  twc_word_t rdata;
  logic enable_q;
  logic [2:0] mode_q;
  logic auto_lock_q;
  logic [NCH-1:0] cmp_en_q;
  logic [NCH-1:0] ov_q;
  logic split_q;
  logic dir_q;
  logic lock_q;
  logic per_bv_q;
  logic [NCH-1:0] cmp_bv_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] per_q;
  logic [15:0] per_buf_q;
  logic [15:0] cmp_q [NCH];
  logic [15:0] cmp_buf_q [NCH];
  logic [NCH-1:0] wg_q;

  // Bus decode; writes land on the edge where pready is seen high
  twc_idx_t idx;
  logic acc;
  logic wr;
  logic mapped;
  assign idx = paddr[7:2];
  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite & pstrb[0];
  assign mapped = idx <= TWC_IDX_LAST;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Byte-lane merge for the 16-bit buffer registers
  function automatic logic [15:0] twc_merge(input logic [15:0] old, input twc_word_t d,
                                             input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0])
    begin
      r[7:0] = d[7:0];
    end
    if (s[1])
    begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : twc_merge

  // Command decode from either companion register
  logic lock_clr_wr;
  logic lock_set_wr;
  logic [1:0] cmd;
  logic cmd_upd;
  logic cmd_restart;
  logic cmd_hard;
  assign lock_clr_wr = wr & (idx == TWC_IDX_LOCK_CLR);
  assign lock_set_wr = wr & (idx == TWC_IDX_LOCK_SET);
  assign cmd = (lock_clr_wr | lock_set_wr) ? pwdata[TWC_LOCK_CMD_LSB +: 2] : TWC_CMD_NONE;
  assign cmd_upd = cmd == TWC_CMD_UPDATE;
  assign cmd_restart = cmd == TWC_CMD_RESTART;
  assign cmd_hard = (cmd == TWC_CMD_HARD) & ~enable_q;

  // Mode decode
  logic dual;
  logic single;
  logic wave_mode;
  logic [15:0] top_val;
  logic run;
  assign dual = (mode_q == TWC_WG_TWO_RAMP_HIGH) | (mode_q == TWC_WG_TWO_RAMP_BOTH)
                | (mode_q == TWC_WG_TWO_RAMP_LOW);
  assign single = mode_q == TWC_WG_SINGLE;
  assign wave_mode = dual | single | (mode_q == TWC_WG_FREQUENCY);
  assign top_val = (mode_q == TWC_WG_FREQUENCY) ? cmp_q[0] : per_q;
  assign run = enable_q & ~split_q;

  // Next count and slope turning points
  logic at_top;
  logic at_bot;
  logic hit_top;
  logic hit_bot;
  logic dir_hw;
  assign at_top = cnt_q == top_val;
  assign at_bot = cnt_q == TWC_CNT_RST;
  always_comb
  begin
    cnt_d = cnt_q;
    dir_hw = dir_q;
    hit_top = 1'b0;
    hit_bot = 1'b0;
    if (run)
    begin
      if (dual)
      begin
        if (!dir_q && at_top)
        begin
          dir_hw = 1'b1;
          cnt_d = cnt_q - 16'h0001;
          hit_top = 1'b1;
        end
        else if (dir_q && at_bot)
        begin
          dir_hw = 1'b0;
          cnt_d = cnt_q + 16'h0001;
          hit_bot = 1'b1;
        end
        else
        begin
          cnt_d = dir_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
        end
      end
      else if (!dir_q)
      begin
        hit_top = at_top;
        cnt_d = at_top ? TWC_CNT_RST : cnt_q + 16'h0001;
      end
      else
      begin
        hit_bot = at_bot;
        cnt_d = at_bot ? top_val : cnt_q - 16'h0001;
      end
    end
  end

  // Update and overflow points per mode; single slope wraps at top counting up, at bottom counting down
  logic upd_hw;
  logic ovf_hw;
  logic update;
  logic transfer;
  logic all_valid;
  always_comb
  begin
    if (single)
    begin
      upd_hw = hit_top | hit_bot;
      ovf_hw = hit_top | hit_bot;
    end
    else if (dual)
    begin
      upd_hw = hit_bot;
      ovf_hw = (mode_q == TWC_WG_TWO_RAMP_HIGH) ? hit_top :
               (mode_q == TWC_WG_TWO_RAMP_BOTH) ? (hit_top | hit_bot) : hit_bot;
    end
    else
    begin
      upd_hw = hit_top;
      ovf_hw = hit_top;
    end
  end
  assign update = upd_hw | cmd_upd;
  assign transfer = update & ~lock_q;
  assign all_valid = &(cmp_bv_q | ~cmp_en_q);

  // Plain control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_q <= 1'b0;
      mode_q <= TWC_MODE_RST;
      auto_lock_q <= 1'b0;
      cmp_en_q <= '0;
      ov_q <= '0;
      split_q <= 1'b0;
    end
    else if (wr)
    begin
      if (idx == TWC_IDX_ENABLE)
        enable_q <= pwdata[0];
      if (idx == TWC_IDX_WAVE)
      begin
        mode_q <= pwdata[TWC_WAVE_MODE_LSB +: 3];
        auto_lock_q <= pwdata[TWC_WAVE_AUTO_LOCK_BIT];
        cmp_en_q <= pwdata[TWC_WAVE_CMPEN_LSB +: NCH];
      end
      if (idx == TWC_IDX_LEVEL)
        ov_q <= pwdata[NCH-1:0];
      if (idx == TWC_IDX_SPLIT)
        split_q <= pwdata[0];
    end
  end

  // Lock bit: auto-lock first, then software companions; hardware set wins
  logic auto_lock_rise;
  assign auto_lock_rise = wr & (idx == TWC_IDX_WAVE) & pwdata[TWC_WAVE_AUTO_LOCK_BIT]
                          & ~auto_lock_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lock_q <= 1'b0;
    else if (auto_lock_rise || (auto_lock_q && transfer))
      lock_q <= 1'b1;
    else if (auto_lock_q && lock_q && all_valid)
      lock_q <= 1'b0;
    else if (lock_set_wr && pwdata[TWC_LOCK_UPDATE_LOCK_BIT])
      lock_q <= 1'b1;
    else if (lock_clr_wr && pwdata[TWC_LOCK_UPDATE_LOCK_BIT])
      lock_q <= 1'b0;
  end

  // Direction: bus writes take priority over the slope logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir_q <= 1'b0;
    else if (cmd_restart || cmd_hard)
      dir_q <= 1'b0;
    else if (lock_set_wr && pwdata[TWC_LOCK_DIR_BIT])
      dir_q <= 1'b1;
    else if (lock_clr_wr && pwdata[TWC_LOCK_DIR_BIT])
      dir_q <= 1'b0;
    else
      dir_q <= dir_hw;
  end

  // Buffer valid flags; a buffer write wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      per_bv_q <= 1'b0;
      cmp_bv_q <= '0;
    end
    else if (cmd_hard)
    begin
      per_bv_q <= 1'b0;
      cmp_bv_q <= '0;
    end
    else
    begin
      per_bv_q <= (per_bv_q & ~transfer
                   & ~(wr && idx == TWC_IDX_BV_CLR && pwdata[TWC_BV_PER_BIT]))
                  | (wr && idx == TWC_IDX_BV_SET && pwdata[TWC_BV_PER_BIT])
                  | (acc && pwrite && idx == TWC_IDX_PER_BUF && !split_q);
      for (int n = 0; n < NCH; n++)
      begin
        cmp_bv_q[n] <= (cmp_bv_q[n] & ~transfer
                        & ~(wr && idx == TWC_IDX_BV_CLR && pwdata[TWC_BV_CMP_LSB+n]))
                       | (wr && idx == TWC_IDX_BV_SET && pwdata[TWC_BV_CMP_LSB+n])
                       | (acc && pwrite && !split_q
                          && idx == TWC_IDX_CMP_BUF0 + twc_idx_t'(n));
      end
    end
  end

  // Period and compare: buffered in normal map, direct in split map
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      per_q <= TWC_PER_RST;
      per_buf_q <= TWC_PER_RST;
      for (int n = 0; n < NCH; n++)
      begin
        cmp_q[n] <= TWC_CMP_RST;
        cmp_buf_q[n] <= TWC_CMP_RST;
      end
    end
    else if (cmd_hard)
    begin
      per_q <= TWC_PER_RST;
      per_buf_q <= TWC_PER_RST;
      for (int n = 0; n < NCH; n++)
      begin
        cmp_q[n] <= TWC_CMP_RST;
        cmp_buf_q[n] <= TWC_CMP_RST;
      end
    end
    else
    begin
      if (acc && pwrite && idx == TWC_IDX_PER_BUF)
      begin
        if (split_q)
          per_q <= twc_merge(per_q, pwdata, pstrb);
        else
          per_buf_q <= twc_merge(per_buf_q, pwdata, pstrb);
      end
      else if (transfer && per_bv_q)
        per_q <= per_buf_q;
      for (int n = 0; n < NCH; n++)
      begin
        if (acc && pwrite && idx == TWC_IDX_CMP_BUF0 + twc_idx_t'(n))
        begin
          if (split_q)
            cmp_q[n] <= twc_merge(cmp_q[n], pwdata, pstrb);
          else
            cmp_buf_q[n] <= twc_merge(cmp_buf_q[n], pwdata, pstrb);
        end
        else if (transfer && cmp_bv_q[n])
          cmp_q[n] <= cmp_buf_q[n];
      end
    end
  end

  // Counter; split runs two byte counters down from the period bytes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= TWC_CNT_RST;
    else if (cmd_restart || cmd_hard)
      cnt_q <= TWC_CNT_RST;
    else if (run)
      cnt_q <= cnt_d;
    else if (enable_q && split_q)
    begin
      cnt_q[7:0] <= (cnt_q[7:0] == 8'h00) ? per_q[7:0] : cnt_q[7:0] - 8'h01;
      cnt_q[15:8] <= (cnt_q[15:8] == 8'h00) ? per_q[15:8] : cnt_q[15:8] - 8'h01;
    end
  end

  // Waveform generator levels
  logic [NCH-1:0] match;
  always_comb
  begin
    for (int n = 0; n < NCH; n++)
      match[n] = run && cnt_q == cmp_q[n];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wg_q <= '0;
    else if (cmd_hard)
      wg_q <= '0;
    else if (!enable_q)
    begin
      if (wr && idx == TWC_IDX_LEVEL)
        wg_q <= pwdata[NCH-1:0];
    end
    else
    begin
      for (int n = 0; n < NCH; n++)
      begin
        if (mode_q == TWC_WG_FREQUENCY && match[n])
          wg_q[n] <= ~wg_q[n];
        else if (single && (hit_top || hit_bot))
          wg_q[n] <= 1'b1;
        else if (single && match[n])
          wg_q[n] <= 1'b0;
        else if (dual && match[n])
          wg_q[n] <= dir_q; // Cleared going up, set going down
      end
    end
  end

  // Pin drive: registered so the pins never glitch on mode writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wave_pin_q <= '0;
      wave_oe_q <= '0;
      overflow_q <= 1'b0;
    end
    else
    begin
      for (int n = 0; n < NCH; n++)
      begin
        wave_oe_q[n] <= wave_mode & cmp_en_q[n];
        wave_pin_q[n] <= (wave_mode & cmp_en_q[n]) ? wg_q[n] : port_level[n];
      end
      overflow_q <= run & ovf_hw;
    end
  end

  // Read mux
  always_comb
  begin
    rdata = '0;
    unique case (idx)
      TWC_IDX_ENABLE: rdata[0] = enable_q;
      TWC_IDX_WAVE:
      begin
        rdata[TWC_WAVE_MODE_LSB +: 3] = mode_q;
        rdata[TWC_WAVE_AUTO_LOCK_BIT] = auto_lock_q;
        rdata[TWC_WAVE_CMPEN_LSB +: NCH] = cmp_en_q;
      end
      TWC_IDX_LEVEL: rdata[NCH-1:0] = ov_q;
      TWC_IDX_SPLIT: rdata[0] = split_q;
      TWC_IDX_LOCK_CLR, TWC_IDX_LOCK_SET:
      begin
        rdata[TWC_LOCK_DIR_BIT] = dir_q;
        rdata[TWC_LOCK_UPDATE_LOCK_BIT] = lock_q; // Command field stays zero
      end
      TWC_IDX_BV_CLR, TWC_IDX_BV_SET:
      begin
        rdata[TWC_BV_PER_BIT] = per_bv_q;
        rdata[TWC_BV_CMP_LSB +: NCH] = cmp_bv_q;
      end
      TWC_IDX_COUNT: rdata[15:0] = cnt_q;
      TWC_IDX_PER_BUF: rdata[15:0] = per_buf_q;
      TWC_IDX_PER_ACT: rdata[15:0] = per_q;
      default:
      begin
        for (int n = 0; n < NCH; n++)
        begin
          if (idx == TWC_IDX_CMP_BUF0 + twc_idx_t'(n))
            rdata[15:0] = cmp_buf_q[n];
          if (idx == TWC_IDX_CMP_ACT0 + twc_idx_t'(n))
            rdata[15:0] = cmp_q[n];
        end
      end
    endcase
  end

  // One wait state keeps read data and ready both registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      prdata_q <= (psel & penable & ~pready_q & ~pwrite & mapped) ? rdata : '0;
    end
  end

  default clocking twc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  halt_when_off_a: assert property (
    (!enable_q && !cmd_restart && !cmd_hard) |=> $stable(cnt_q))
    else $error("counter moved while disabled");

  pin_route_a: assert property (
    (wave_mode && cmp_en_q[0]) |=> (wave_oe_q[0] && wave_pin_q[0] == $past(wg_q[0])))
    else $error("waveform not routed to pin");

  no_wave_normal_a: assert property (
    (mode_q == TWC_WG_NORMAL) |=> (wave_oe_q == '0))
    else $error("waveform output in normal mode");

  autolock_release_a: assert property (
    (auto_lock_q && lock_q && all_valid) |=> !lock_q)
    else $error("auto-lock did not release");

  autolock_relock_a: assert property (
    (auto_lock_q && transfer) |=> lock_q)
    else $error("auto-lock did not relock after transfer");

  manual_lock_a: assert property (
    (!auto_lock_q && !auto_lock_rise && !lock_set_wr && !lock_clr_wr) |=> $stable(lock_q))
    else $error("lock changed without software");

  locked_no_load_a: assert property (
    (lock_q && !cmd_hard && !split_q) |=> ($stable(per_q) && $stable(cmp_q[0])))
    else $error("buffer loaded while locked");

  update_load_a: assert property (
    (transfer && per_bv_q && !cmd_hard && !split_q
     && !(acc && pwrite && idx == TWC_IDX_PER_BUF)) // Bus write wins that edge
    |=> (per_q == $past(per_buf_q) && !per_bv_q))
    else $error("period buffer not loaded on update");

  hard_ignored_a: assert property (
    (cmd == TWC_CMD_HARD && enable_q) |=> $stable(per_buf_q))
    else $error("hard reset acted while enabled");

  count_up_a: assert property (
    (run && !dual && !dir_q && !at_top && cmd == TWC_CMD_NONE) |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("counter did not increment");

  cmd_read_zero_a: assert property (
    (pready_q && !pwrite && (idx == TWC_IDX_LOCK_CLR || idx == TWC_IDX_LOCK_SET))
    |-> (prdata_q[TWC_LOCK_CMD_LSB +: 2] == 2'b00))
    else $error("command field read nonzero");

  autolock_cycle_c: cover property (auto_lock_q && lock_q ##1 !lock_q ##[1:200] lock_q);
  dual_turn_c: cover property (dual && hit_top ##[1:200] hit_bot);
  forced_update_c: cover property (cmd_upd && transfer);

endmodule : twc_timer_ctrl

// >>> design/twc_pkg.sv
package twc_pkg;

  // Bus word and address carriers
  typedef logic [31:0] twc_word_t;
  typedef logic [7:0] twc_addr_t;
  typedef logic [5:0] twc_idx_t;

  // Register indices; byte address is four times the index
  localparam twc_idx_t TWC_IDX_ENABLE = 6'h00;
  localparam twc_idx_t TWC_IDX_WAVE = 6'h01;
  localparam twc_idx_t TWC_IDX_LEVEL = 6'h02;
  localparam twc_idx_t TWC_IDX_SPLIT = 6'h03;
  localparam twc_idx_t TWC_IDX_LOCK_CLR = 6'h04;
  localparam twc_idx_t TWC_IDX_LOCK_SET = 6'h05;
  localparam twc_idx_t TWC_IDX_BV_CLR = 6'h06;
  localparam twc_idx_t TWC_IDX_BV_SET = 6'h07;
  localparam twc_idx_t TWC_IDX_COUNT = 6'h08;
  localparam twc_idx_t TWC_IDX_PER_BUF = 6'h09;
  localparam twc_idx_t TWC_IDX_CMP_BUF0 = 6'h0a;
  localparam twc_idx_t TWC_IDX_PER_ACT = 6'h0d;
  localparam twc_idx_t TWC_IDX_CMP_ACT0 = 6'h0e;
  localparam twc_idx_t TWC_IDX_LAST = 6'h10;

  // Field positions
  localparam int TWC_WAVE_MODE_LSB = 0;
  localparam int TWC_WAVE_AUTO_LOCK_BIT = 3;
  localparam int TWC_WAVE_CMPEN_LSB = 4;
  localparam int TWC_LOCK_DIR_BIT = 0;
  localparam int TWC_LOCK_UPDATE_LOCK_BIT = 1;
  localparam int TWC_LOCK_CMD_LSB = 2;
  localparam int TWC_BV_PER_BIT = 0;
  localparam int TWC_BV_CMP_LSB = 1;

  // Waveform mode codes
  localparam logic [2:0] TWC_WG_NORMAL = 3'h0;
  localparam logic [2:0] TWC_WG_FREQUENCY = 3'h1;
  localparam logic [2:0] TWC_WG_SINGLE = 3'h3;
  localparam logic [2:0] TWC_WG_TWO_RAMP_HIGH = 3'h5;
  localparam logic [2:0] TWC_WG_TWO_RAMP_BOTH = 3'h6;
  localparam logic [2:0] TWC_WG_TWO_RAMP_LOW = 3'h7;

  // Command codes
  localparam logic [1:0] TWC_CMD_NONE = 2'h0;
  localparam logic [1:0] TWC_CMD_UPDATE = 2'h1;
  localparam logic [1:0] TWC_CMD_RESTART = 2'h2;
  localparam logic [1:0] TWC_CMD_HARD = 2'h3;

  // Values after reset
  localparam logic [15:0] TWC_PER_RST = 16'hffff;
  localparam logic [15:0] TWC_CNT_RST = 16'h0000;
  localparam logic [15:0] TWC_CMP_RST = 16'h0000;
  localparam logic [2:0] TWC_MODE_RST = 3'h0;

endpackage : twc_pkg

// >>> sim/twc_timer_ctrl_bench.sv
`timescale 1ns/10ps
module twc_timer_ctrl_bench;
  import twc_pkg::*;
  logic pclk;
  logic presetn;
  twc_addr_t paddr;
  logic psel;
  logic penable;
  logic pwrite;
  twc_word_t pwdata;
  logic [3:0] pstrb;
  twc_word_t prdata;
  logic pready;
  logic pslverr;
  logic [2:0] port_level;
  logic [2:0] wave_pin_q;
  logic [2:0] wave_oe_q;
  logic overflow_q;
  int err_count;
  int comparisons;
  twc_word_t rd;
  logic rerr;

  twc_timer_ctrl #(.NCH(3)) u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .port_level(port_level),
    .wave_pin_q(wave_pin_q),
    .wave_oe_q(wave_oe_q),
    .overflow_q(overflow_q)
  );

  // Free-running bus clock, 4 ns period
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic summarize();
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input twc_word_t got, input twc_word_t exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // One transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input twc_idx_t idx, input twc_word_t data);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h1, "bus answer");
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input twc_idx_t idx, input twc_word_t data);
    apb(1'b1, idx, data);
  endtask : wr

  task automatic rdx(input twc_idx_t idx, input twc_word_t exp, input string msg);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp, msg);
  endtask : rdx

  // Edges from one overflow pulse to the next; first interval discarded
  task automatic gap(output int g);
    int n;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (overflow_q !== 1'b1 && n < 100);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (overflow_q !== 1'b1 && n < 100);
    g = n;
  endtask : gap

  task automatic t_reset();
    for (int i = 0; i < 8; i++)
      rdx(twc_idx_t'(i), 32'h0, "reset value");
    rdx(TWC_IDX_PER_BUF, 32'hffff, "period buffer reset");
    rdx(TWC_IDX_PER_ACT, 32'hffff, "period reset");
    apb(1'b0, 6'h11, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
  endtask : t_reset

  task automatic t_companion();
    wr(TWC_IDX_LOCK_SET, 32'h3);
    rdx(TWC_IDX_LOCK_CLR, 32'h3, "set companion");
    wr(TWC_IDX_LOCK_SET, 32'h0);
    rdx(TWC_IDX_LOCK_SET, 32'h3, "zero write keeps");
    wr(TWC_IDX_LOCK_CLR, 32'h1);
    rdx(TWC_IDX_LOCK_SET, 32'h2, "clear companion");
    wr(TWC_IDX_LOCK_CLR, 32'h2);
    wr(TWC_IDX_BV_SET, 32'h5);
    wr(TWC_IDX_BV_CLR, 32'h1);
    rdx(TWC_IDX_BV_CLR, 32'h4, "valid companions");
    wr(TWC_IDX_BV_CLR, 32'h4);
    wr(TWC_IDX_LOCK_SET, 32'h8);
    rdx(TWC_IDX_LOCK_SET, 32'h0, "command reads zero");
  endtask : t_companion

  task automatic t_update();
    wr(TWC_IDX_CMP_BUF0, 32'h3);
    wr(TWC_IDX_PER_BUF, 32'h7);
    rdx(TWC_IDX_BV_SET, 32'h3, "valid on write");
    wr(TWC_IDX_LOCK_SET, 32'h2);
    wr(TWC_IDX_LOCK_SET, 32'h4);
    rdx(TWC_IDX_PER_ACT, 32'hffff, "locked update");
    wr(TWC_IDX_LOCK_CLR, 32'h2);
    wr(TWC_IDX_LOCK_SET, 32'h4);
    rdx(TWC_IDX_PER_ACT, 32'h7, "forced update");
    rdx(TWC_IDX_CMP_ACT0, 32'h3, "compare update");
    rdx(TWC_IDX_BV_SET, 32'h0, "valid cleared");
    wr(TWC_IDX_ENABLE, 32'h1);
    wr(TWC_IDX_PER_BUF, 32'h9);
    wr(TWC_IDX_LOCK_SET, 32'hc);
    rdx(TWC_IDX_PER_BUF, 32'h9, "hard reset ignored");
    wr(TWC_IDX_ENABLE, 32'h0);
    wr(TWC_IDX_LOCK_SET, 32'hc);
    rdx(TWC_IDX_PER_BUF, 32'hffff, "hard reset");
    rdx(TWC_IDX_COUNT, 32'h0, "hard reset count");
  endtask : t_update

  task automatic t_run();
    twc_word_t c1;
    rdx(TWC_IDX_COUNT, 32'h0, "halted");
    wr(TWC_IDX_ENABLE, 32'h1);
    apb(1'b0, TWC_IDX_COUNT, 32'h0);
    c1 = rd;
    apb(1'b0, TWC_IDX_COUNT, 32'h0);
    chk({31'h0, rd > c1}, 32'h1, "count up");
    wr(TWC_IDX_LOCK_SET, 32'h1);
    apb(1'b0, TWC_IDX_COUNT, 32'h0);
    c1 = rd;
    apb(1'b0, TWC_IDX_COUNT, 32'h0);
    chk({31'h0, rd < c1}, 32'h1, "count down");
    wr(TWC_IDX_ENABLE, 32'h0);
    apb(1'b0, TWC_IDX_COUNT, 32'h0);
    c1 = rd;
    rdx(TWC_IDX_COUNT, c1, "held");
    wr(TWC_IDX_LOCK_SET, 32'h8);
    rdx(TWC_IDX_LOCK_SET, 32'h0, "restart dir");
  endtask : t_run

  task automatic t_autolock();
    wr(TWC_IDX_WAVE, 32'h18);
    rdx(TWC_IDX_LOCK_SET, 32'h2, "auto lock set");
    wr(TWC_IDX_CMP_BUF0, 32'h5);
    rdx(TWC_IDX_LOCK_SET, 32'h0, "auto release");
    rdx(TWC_IDX_CMP_ACT0, 32'h0, "no early load");
    wr(TWC_IDX_LOCK_SET, 32'h4);
    rdx(TWC_IDX_CMP_ACT0, 32'h5, "auto transfer");
    rdx(TWC_IDX_LOCK_SET, 32'h2, "relock");
    wr(TWC_IDX_WAVE, 32'h10);
    wr(TWC_IDX_CMP_BUF0, 32'h3);
    wr(TWC_IDX_PER_BUF, 32'h7);
    rdx(TWC_IDX_LOCK_SET, 32'h2, "lock kept");
    wr(TWC_IDX_LOCK_CLR, 32'h2);
    wr(TWC_IDX_LOCK_SET, 32'h4);
    rdx(TWC_IDX_LOCK_SET, 32'h0, "no relock");
    rdx(TWC_IDX_PER_ACT, 32'h7, "period loaded");
  endtask : t_autolock

  task automatic t_pins();
    wr(TWC_IDX_LEVEL, 32'h5);
    port_level <= 3'b010;
    wr(TWC_IDX_WAVE, 32'h73);
    repeat (3) @(posedge pclk);
    chk({29'h0, wave_oe_q}, 32'h7, "override");
    chk({29'h0, wave_pin_q}, 32'h5, "forced level");
    wr(TWC_IDX_WAVE, 32'h53);
    repeat (3) @(posedge pclk);
    chk({29'h0, wave_pin_q}, 32'h7, "mixed pins");
    wr(TWC_IDX_WAVE, 32'h70);
    repeat (3) @(posedge pclk);
    chk({26'h0, wave_oe_q, wave_pin_q}, 32'h2, "normal mode");
    wr(TWC_IDX_WAVE, 32'h72);
    repeat (3) @(posedge pclk);
    chk({29'h0, wave_oe_q}, 32'h0, "reserved mode");
    wr(TWC_IDX_WAVE, 32'h11);
    repeat (3) @(posedge pclk);
    chk({29'h0, wave_oe_q}, 32'h1, "frequency pin");
    rdx(TWC_IDX_WAVE, 32'h11, "wave readback");
    rdx(TWC_IDX_LEVEL, 32'h5, "level readback");
  endtask : t_pins

  // Overflow spacing per mode, period 7 and compare 0 at 3
  task automatic t_modes();
    logic [2:0] md[6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    int ex[6] = '{8, 4, 8, 14, 7, 14};
    int g;
    for (int i = 0; i < 6; i++)
    begin
      wr(TWC_IDX_ENABLE, 32'h0);
      wr(TWC_IDX_WAVE, {29'h0, md[i]});
      wr(TWC_IDX_LOCK_SET, 32'h8);
      wr(TWC_IDX_ENABLE, 32'h1);
      gap(g);
      chk(twc_word_t'(g), twc_word_t'(ex[i]), "overflow spacing");
    end
    wr(TWC_IDX_ENABLE, 32'h0);
  endtask : t_modes

  task automatic t_split();
    twc_word_t c1;
    wr(TWC_IDX_SPLIT, 32'h1);
    rdx(TWC_IDX_SPLIT, 32'h1, "split readback");
    wr(TWC_IDX_ENABLE, 32'h1);
    apb(1'b0, TWC_IDX_COUNT, 32'h0);
    c1 = rd;
    apb(1'b0, TWC_IDX_COUNT, 32'h0);
    chk({31'h0, rd[7:0] <= 8'h07 && rd != c1}, 32'h1, "split count");
    wr(TWC_IDX_ENABLE, 32'h0);
    wr(TWC_IDX_SPLIT, 32'h0);
  endtask : t_split

  // Hang guard, far beyond the several hundred cycles the run needs
  initial
  begin
    #40000;
    err_count++;
    summarize();
  end

  initial
  begin
    err_count = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    port_level = 3'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_companion();
    t_update();
    t_run();
    t_autolock();
    t_pins();
    t_modes();
    t_split();
    summarize();
  end
endmodule : twc_timer_ctrl_bench
